// ### dv/serial_flash_spi_front_end_tb.sv
// self-checking bench: host side of the serial link, modes 0 and 3
// assumes the array model as back end, 250 MHz core clock
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module serial_flash_spi_front_end_tb
   import sfs_pkg::*;
;
   logic clock, reset, cs_n, sclk, hold_n, guard_n, h0, h1;
   logic o0, e0, o1, e1, pd, pz, done;
   logic [7:0] rdata;
   sfs_mem_req_t req, last;
   sfs_status_t st;
   wire w0 = e0 ? h0 : o0;
   wire w1 = e1 ? h1 : o1;
   int bad_count = 0, check_count = 0, ncmd = 0;
   sfs_front_end dut_u (.clock(clock), .reset(reset), .spi_cs_n(cs_n),
      .spi_clk(sclk), .pause_n(hold_n), .write_guard_n(guard_n),
      .dual_line_0_in(w0), .dual_line_0_out(o0), .dual_line_0_oe_n(e0),
      .dual_line_1_in(w1), .dual_line_1_out(o1), .dual_line_1_oe_n(e1),
      .mem_req(req), .mem_rdata(rdata), .mem_done(done), .status(st),
      .power_down(pd), .paused(pz));
   sfs_array_model #(.LAT(600)) mem_u (.clock(clock), .reset(reset),
      .mem_req(req), .mem_rdata(rdata), .mem_done(done));
   always @(posedge clock) if (req.cmd_valid) begin
      ncmd <= ncmd + 1;
      last <= req;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n); repeat (n) @(negedge clock); endtask
   // sample at end of high phase: bit launched by the previous fall
   task automatic bit1(input logic d0, d1, output logic r0, r1);
      h0 = d0; h1 = d1; sclk = 0; cyc(4);
      sclk = 1; cyc(4); r0 = w0; r1 = w1;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      logic a;
      for (int i = 7; i >= 0; i--) bit1(tx[i], ~h1, a, rx[i]);
   endtask
   task automatic xfer2(output logic [7:0] rx);
      logic a, b;
      for (int i = 7; i > 0; i -= 2) begin
         bit1(~h0, ~h1, a, b); rx[i] = b; rx[i-1] = a;
      end
   endtask
   task automatic sel; cs_n = 0; cyc(4); endtask
   task automatic desel; sclk = 0; cyc(2); cs_n = 1; cyc(12); endtask
   task automatic cmd1(input logic [7:0] op);
      logic [7:0] r;
      sel; xfer(op, r); desel;
   endtask
   task automatic rdsr(output logic [7:0] s);
      logic [7:0] r;
      sel; xfer(8'h05, r); xfer(8'h00, s); desel;
   endtask
   task automatic opaddr(input logic [7:0] op, input logic [23:0] a);
      logic [7:0] r;
      sel; xfer(op, r); xfer(a[23:16], r); xfer(a[15:8], r); xfer(a[7:0], r);
   endtask
   task automatic wrsr(input logic [7:0] v);
      logic [7:0] r;
      cmd1(8'h06); sel; xfer(8'h01, r); xfer(v, r); desel; cyc(700);
   endtask
   task automatic t_lockout;
      logic [7:0] s;
      cmd1(8'h06); rdsr(s);
      chk(s, 8'h00);
      chk(st, 8'h00);
      $display("t_lockout done");
   endtask
   task automatic t_wel;
      logic [7:0] s;
      cmd1(8'h06); rdsr(s);
      chk(s, 8'h02);
      cmd1(8'h04);
      chk(st.write_latch_flag, 1'b0);
      $display("t_wel done");
   endtask
   task automatic t_erase;
      logic [7:0] s;
      int n;
      n = ncmd;
      cmd1(8'h06); opaddr(8'h20, 24'h012345); desel;
      chk(ncmd, n + 1);
      chk(last.op, OP_ERASE4);
      chk(last.addr, 18'h12345);
      rdsr(s);
      chk(s, 8'h03);
      opaddr(8'h20, 24'h000000); desel;
      chk(ncmd, n + 1);
      cyc(300); rdsr(s);
      chk(s, 8'h00);
      cmd1(8'h06); opaddr(8'h02, 24'h000102); xfer(8'h3C, s); desel;
      chk(last, {1'b1, OP_PROGRAM, 2'b00, 18'h00102, 8'h3C});
      cyc(700);
      $display("t_erase done");
   endtask
   task automatic t_protect;
      int n;
      wrsr(8'h04);
      chk(st, 8'h04);
      n = ncmd;
      cmd1(8'h06); opaddr(8'h20, 24'h03F000); desel;
      chk(ncmd, n);
      wrsr(8'h84);
      guard_n = 0; wrsr(8'h00);
      chk(st, 8'h86);
      guard_n = 1; wrsr(8'h00);
      chk(st, 8'h00);
      $display("t_protect done");
   endtask
   task automatic t_read;
      logic [7:0] r;
      opaddr(8'h03, 24'h0001FF);
      xfer(8'h00, r);
      chk(r, 8'hA5);
      xfer(8'h00, r);
      chk(r, 8'h5A);
      desel;
      chk({e1, e0}, 2'h3);
      $display("t_read done");
   endtask
   task automatic t_dual;
      logic [7:0] r;
      opaddr(8'h3B, 24'h000010); xfer(8'h00, r);
      xfer2(r);
      chk(r, 8'h4A);
      xfer2(r);
      chk(r, 8'h4B);
      desel;
      $display("t_dual done");
   endtask
   task automatic t_pause;
      logic [7:0] r;
      logic a, b;
      sel; xfer(8'h03, r); xfer(8'h00, r);
      sclk = 0; cyc(4); hold_n = 0; cyc(6);
      chk(pz, 1'b1);
      repeat (3) bit1(1'b1, ~h1, a, b);
      sclk = 0; cyc(4);
      chk({pz, e1}, 2'h3);
      hold_n = 1; cyc(6);
      chk(pz, 1'b0);
      xfer(8'h01, r); xfer(8'h00, r); xfer(8'h00, r);
      chk(r, 8'h5A);
      desel;
      $display("t_pause done");
   endtask
   task automatic t_sleep;
      cmd1(8'hB9);
      chk(pd, 1'b1);
      cmd1(8'h06);
      chk(st.write_latch_flag, 1'b0);
      cmd1(8'hAB);
      chk(pd, 1'b0);
      $display("t_sleep done");
   endtask
   task automatic t_mode3;
      logic [7:0] r;
      logic a;
      sclk = 1; cyc(2); sel; repeat (3) bit1(1'b1, 1'b0, a, a);
      cs_n = 1; cyc(12); sel; xfer(8'h05, r); xfer(8'h00, r);
      cs_n = 1; cyc(12);
      chk(r, 8'h00);
      $display("t_mode3 done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   // run is near 11000 cycles; the limit leaves wide margin
   initial begin
      #160000;
      bad_count++;
      final_report;
   end
   initial begin
      reset = 1; cs_n = 1; sclk = 0; hold_n = 1; guard_n = 1; h0 = 0; h1 = 0;
      cyc(3); reset = 0; cyc(8);
      t_lockout; cyc(2600);
      t_wel; t_erase; t_protect; t_read; t_dual; t_pause; t_sleep; t_mode3;
      final_report;
   end
endmodule
`default_nettype wire

// ### dv/sfs_array_model.sv
// array back end model: read bytes and slow operation completion
// assumes mem_req from the front end, same clock
`timescale 1ns/1ps
`default_nettype none
// ----
// model
// ----
module sfs_array_model
   import sfs_pkg::*;
#(
   parameter int LAT = 600
)
(
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire sfs_mem_req_t mem_req,
   output logic [7:0]        mem_rdata,
   output logic              mem_done
);
   int unsigned wait_cnt;
   // stale read data changes every cycle so late capture shows up
   always_ff @(posedge clock) begin
      if (mem_req.rd_valid)
         mem_rdata <= mem_req.addr[7:0] ^ 8'h5A;
      else
         mem_rdata <= ~mem_rdata;
   end
   always_ff @(posedge clock) begin
      mem_done <= 1'b0;
      if (reset)
         wait_cnt <= 0;
      else if (mem_req.cmd_valid)
         wait_cnt <= LAT;
      else if (wait_cnt == 1) begin
         wait_cnt <= 0;
         mem_done <= 1'b1;
      end else if (wait_cnt != 0)
         wait_cnt <= wait_cnt - 1;
   end
endmodule
`default_nettype wire

// ### dv/sfs_front_end_properties.sv
// port assertions for the serial flash front end
// assumes one core clock domain with synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defines.svh"
// ----
// checker
// ----
module sfs_fe_properties
   import sfs_pkg::*;
(
   input wire logic         clock,
   input wire logic         reset,
   input wire logic         spi_cs_n,
   input wire logic         dual_line_0_oe_n,
   input wire logic         dual_line_1_oe_n,
   input wire sfs_mem_req_t mem_req,
   input wire logic         mem_done,
   input wire sfs_status_t  status,
   input wire logic         power_down,
   input wire logic         paused
);
   int unsigned since_rst;
   // saturates, so a long run never wraps
   always_ff @(posedge clock) begin
      if (reset)
         since_rst <= 0;
      else if (since_rst < `SFS_PUW_CYCLES)
         since_rst <= since_rst + 1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence op_start; mem_req.cmd_valid; endsequence
   sequence op_end; mem_done && status.busy; endsequence
   busy_on_start_a: assert property (op_start |-> status.busy && status.write_latch_flag)
      else $error("command without busy and latch");
   done_clears_a: assert property (op_end |=> !status.busy && !status.write_latch_flag)
      else $error("completion left busy or latch set");
   start_pulse_a: assert property (op_start |=> !mem_req.cmd_valid)
      else $error("command pulse too long");
   deselect_float_a: assert property (spi_cs_n [*8] |-> dual_line_0_oe_n && dual_line_1_oe_n)
      else $error("line driven while deselected");
   pause_float_a: assert property (paused [*2] |-> dual_line_0_oe_n && dual_line_1_oe_n)
      else $error("line driven while paused");
   lockout_latch_a: assert property (status.write_latch_flag |-> since_rst >= `SFS_PUW_CYCLES)
      else $error("latch set during power-up lockout");
   sleep_entry_a: assert property ($rose(power_down) |-> spi_cs_n)
      else $error("power-down entered while selected");
   sleep_quiet_a: assert property (power_down |-> !mem_req.cmd_valid)
      else $error("command issued in power-down");
   reset_clean_a: assert property (disable iff (1'b0) reset |=> status == 8'h00 && !paused)
      else $error("state not cleared by reset");
endmodule
bind sfs_front_end sfs_fe_properties chk_u (
   .clock(clock), .reset(reset), .spi_cs_n(spi_cs_n),
   .dual_line_0_oe_n(dual_line_0_oe_n), .dual_line_1_oe_n(dual_line_1_oe_n),
   .mem_req(mem_req), .mem_done(mem_done), .status(status),
   .power_down(power_down), .paused(paused));
`default_nettype wire

// ### shared/sfs_defines.svh
// constants of the serial flash front end: opcodes, sizes, timing
// assumes a 250 MHz core clock sampling every serial pin
//
// Behaviour
// RQ1 - chip select high deselects, floats outputs, running operation still finishes
// RQ2 - nothing is accepted before a chip select falling edge after reset
// RQ3 - single mode: capture input on clock rise, drive output on clock fall
// RQ4 - only clock modes 0 and 3; idle clock level is free at select edges
// RQ5 - dual reads turn both data lines into two-bit bidirectional lines
// RQ6 - dual mode: capture both lines on rise, drive both lines on fall
// RQ7 - pause starts with pause_n low and clock low, select low
// RQ8 - pause ends with pause_n high and clock low; instruction resumes
// RQ9 - while paused outputs float, clock and data ignored, state kept
// RQ10 - host keeps select low during pause; raising it resets instruction state
// RQ11 - supply monitor reset disables everything, no instruction recognised
// RQ12 - after reset, write-type instructions refused for the power-up delay
// RQ13 - write latch flag is 0 after power-up
// RQ14 - program, erase, status write need the write latch flag set first
// RQ15 - completion of program, erase or status write clears the write latch
// RQ16 - in power-down only the release instruction is obeyed
// RQ17 - write guard input is active low and gates status writes with lock bit
// RQ18 - busy bit S0 is 1 during operations; then only status read obeyed
// RQ19 - write latch flag sits at S1, set by write enable, read only
// RQ20 - side select picks top or bottom; size code none, quarter, half, all
// RQ21 - lock bit S7 set and guard low refuses status writes
// RQ22 - program or erase touching a protected region is ignored
// RQ23 - select rising edge ends the transaction and clears shift state
// RQ24 - single mode output floats unless read data or status is driven
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

`define SFS_OP_WREN      8'h06
`define SFS_OP_WRDI      8'h04
`define SFS_OP_RDSR      8'h05
`define SFS_OP_WRSR      8'h01
`define SFS_OP_READ      8'h03
`define SFS_OP_FAST      8'h0B
`define SFS_OP_DOUT      8'h3B
`define SFS_OP_DIO       8'hBB
`define SFS_OP_PROG      8'h02
`define SFS_OP_SE        8'h20
`define SFS_OP_BE32      8'h52
`define SFS_OP_BE64      8'hD8
`define SFS_OP_CE        8'hC7
`define SFS_OP_CE_ALT    8'h60
`define SFS_OP_PD        8'hB9
`define SFS_OP_RPD       8'hAB

`define SFS_ARRAY_BYTES  19'h40000
`define SFS_QUARTER      19'h10000
`define SFS_SPAN_PAGE    19'h00100
`define SFS_SPAN_4K      19'h01000
`define SFS_SPAN_32K     19'h08000
`define SFS_SPAN_64K     19'h10000
`define SFS_ADDR_BITS    6'h18
`define SFS_ADDR_BITS_DIO 6'h20
`define SFS_STATUS_RESET 8'h00

`define SFS_CLK_PERIOD_PS 4000
`define SFS_PUW_TIME_NS  10000
`define SFS_PUW_CYCLES \
   ((`SFS_PUW_TIME_NS * 1000 + `SFS_CLK_PERIOD_PS - 1) / `SFS_CLK_PERIOD_PS)

`endif

// ### shared/sfs_pkg.sv
// types of the serial flash front end
// assumes sfs_defines.svh for all numeric constants
package sfs_pkg;

   typedef enum logic [2:0] {
      S_CMD    = 3'b000,
      S_ADDR   = 3'b001,
      S_DUMMY  = 3'b010,
      S_WDATA  = 3'b011,
      S_RDATA  = 3'b100,
      S_DONE   = 3'b101,
      S_IGNORE = 3'b110
   } sfs_state_t;

   typedef enum logic [2:0] {
      OP_NONE    = 3'b000,
      OP_PROGRAM = 3'b001,
      OP_ERASE4  = 3'b010,
      OP_ERASE32 = 3'b011,
      OP_ERASE64 = 3'b100,
      OP_CHIP    = 3'b101,
      OP_STATUS  = 3'b110
   } sfs_op_t;

   // S7 down to S0
   typedef struct packed {
      logic       lock;
      logic       rsv6;
      logic       side;
      logic       rsv4;
      logic [1:0] size;
      logic       write_latch_flag;
      logic       busy;
   } sfs_status_t;

   typedef struct packed {
      logic        cmd_valid;
      sfs_op_t     op;
      logic        wr_valid;
      logic        rd_valid;
      logic [17:0] addr;
      logic [7:0]  wdata;
   } sfs_mem_req_t;

endpackage

// ### verilog/sfs_front_end.sv
// serial flash front end: pin sampling, instruction engine, status
// assumes an array back end that answers reads within one clock and
// pulses mem_done when a started operation has finished
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defines.svh"

module sfs_front_end
   import sfs_pkg::*;
(
   // clock and supply-monitor reset
   input  wire logic   clock,
   input  wire logic   reset,
   // serial pins
   input  wire logic   spi_cs_n,
   input  wire logic   spi_clk,
   input  wire logic   pause_n,
   input  wire logic   write_guard_n,
   input  wire logic   dual_line_0_in,
   output logic        dual_line_0_out,
   output logic        dual_line_0_oe_n,
   input  wire logic   dual_line_1_in,
   output logic        dual_line_1_out,
   output logic        dual_line_1_oe_n,
   // array side
   output sfs_mem_req_t mem_req,
   input  wire logic [7:0] mem_rdata,
   input  wire logic   mem_done,
   // state seen from outside
   output sfs_status_t status,
   output logic        power_down,
   output logic        paused
);

   // ----------------------------------------------------------
   // functions
   // ----------------------------------------------------------
   function automatic logic [18:0] span_of(input logic [7:0] opc);
      logic [18:0] s;
      s = `SFS_SPAN_PAGE;
      if (opc == `SFS_OP_SE)
         s = `SFS_SPAN_4K;
      else if (opc == `SFS_OP_BE32)
         s = `SFS_SPAN_32K;
      else if (opc == `SFS_OP_BE64)
         s = `SFS_SPAN_64K;
      return s;
   endfunction

   // overlap of the aligned target region with the protected region
   function automatic logic prot_hit(input sfs_status_t st,
                                     input logic [17:0] a,
                                     input logic [18:0] span);
      logic [18:0] psz;
      logic [18:0] plo;
      logic [18:0] phi;
      logic [18:0] lo;
      logic [18:0] hi;
      psz = (st.size == 2'b11) ? `SFS_ARRAY_BYTES :
            (st.size == 2'b10) ? (`SFS_QUARTER << 1) : `SFS_QUARTER;
      plo = st.side ? 19'h00000 : (`SFS_ARRAY_BYTES - psz);
      phi = st.side ? (psz - 19'h00001) : (`SFS_ARRAY_BYTES - 19'h00001);
      lo  = {1'b0, a} & ~(span - 19'h00001);
      hi  = lo + span - 19'h00001;
      return (st.size != 2'b00) && (lo <= phi) && (hi >= plo); // [RQ20]
   endfunction

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       cs_d;
   logic       clk_d;
   logic       cs_s;
   logic       clk_s;
   logic       pause_s;
   logic       guard_s;
   logic       d1_s;
   logic       d0_s;

   assign {cs_s, clk_s, pause_s, guard_s, d1_s, d0_s} = sync2;

   // cs and clock reset low, pause high: no false falling edge or pause follows
   always_ff @(posedge clock) begin
      if (reset) begin
         sync1 <= 6'h0C;
         sync2 <= 6'h0C;
         cs_d  <= 1'b0;
         clk_d <= 1'b0;
      end else begin
         sync1 <= {spi_cs_n, spi_clk, pause_n, write_guard_n,
                   dual_line_1_in, dual_line_0_in};
         sync2 <= sync1;
         cs_d  <= cs_s;
         clk_d <= clk_s;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic clk_rise;
   logic clk_fall;

   assign cs_fall  = cs_d & ~cs_s;
   assign cs_rise  = ~cs_d & cs_s;
   assign clk_rise = clk_s & ~clk_d;  // [RQ4]
   assign clk_fall = ~clk_s & clk_d;

   // ----------------------------------------------------------
   // select and pause
   // ----------------------------------------------------------
   logic sel;

   always_ff @(posedge clock) begin
      if (reset) begin
         sel <= 1'b0;  // [RQ11]
      end else if (cs_fall) begin
         sel <= 1'b1;  // [RQ2]
      end else if (cs_s) begin
         sel <= 1'b0;  // [RQ1]
      end
   end

   // a pause may hold across a clock high phase, so it acts on clock low
   always_ff @(posedge clock) begin
      if (reset || cs_s) begin
         paused <= 1'b0;  // [RQ10]
      end else if (!paused && !pause_s && !clk_s) begin
         paused <= 1'b1;  // [RQ7]
      end else if (paused && pause_s && !clk_s) begin
         paused <= 1'b0;  // [RQ8]
      end
   end

   // ----------------------------------------------------------
   // power-up write lockout
   // ----------------------------------------------------------
   logic [11:0] puw_cnt;
   logic        puw_active;

   assign puw_active = (puw_cnt != 12'h000);

   always_ff @(posedge clock) begin
      if (reset) begin
         puw_cnt <= 12'(`SFS_PUW_CYCLES);  // [RQ12]
      end else if (puw_active) begin
         puw_cnt <= puw_cnt - 12'h001;
      end
   end

   // ----------------------------------------------------------
   // instruction engine
   // ----------------------------------------------------------
   sfs_state_t  state;
   logic [7:0]  opcode;
   logic [7:0]  shift;
   logic [31:0] addr_sh;
   logic [5:0]  bit_cnt;
   logic [7:0]  new_sr;
   logic        got_byte;
   logic [7:0]  obuf;
   logic [2:0]  out_cnt;
   logic        started;
   logic        drv1;
   logic        drv0;

   logic        go;
   logic        dual_in;
   logic        dual_out;
   logic [31:0] next_sh;
   logic [5:0]  next_cnt;
   logic [7:0]  next_byte;
   logic [7:0]  opc;
   logic [17:0] tgt;
   logic        gate_ok;
   logic        wr_ok;
   logic [7:0]  rd_byte;

   always_comb begin
      go       = sel & ~cs_s & ~paused;  // [RQ9]
      dual_in  = (state == S_ADDR) && (opcode == `SFS_OP_DIO);
      dual_out = (opcode == `SFS_OP_DOUT) || (opcode == `SFS_OP_DIO); // [RQ5]
      next_sh  = dual_in ? {addr_sh[29:0], d1_s, d0_s}
                         : {addr_sh[30:0], d0_s};  // [RQ6]
      next_cnt = bit_cnt + (dual_in ? 6'h02 : 6'h01);
      next_byte = {shift[6:0], d0_s};  // [RQ3]
      opc      = next_byte;
      tgt      = (opcode == `SFS_OP_DIO) ? next_sh[25:8] : next_sh[17:0];
      // only release in power-down, only status read while busy
      gate_ok  = power_down ? (opc == `SFS_OP_RPD)
               : status.busy ? (opc == `SFS_OP_RDSR) : 1'b1; // [RQ16] [RQ18]
      wr_ok    = gate_ok & status.write_latch_flag & ~puw_active;  // [RQ14] [RQ12]
      rd_byte  = (opcode == `SFS_OP_RDSR) ? status : mem_rdata;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state      <= S_CMD;
         opcode     <= 8'h00;
         shift      <= 8'h00;
         addr_sh    <= 32'h00000000;
         bit_cnt    <= 6'h00;
         new_sr     <= 8'h00;
         got_byte   <= 1'b0;
         obuf       <= 8'h00;
         out_cnt    <= 3'h0;
         started    <= 1'b0;
         drv1       <= 1'b0;
         drv0       <= 1'b0;
         power_down <= 1'b0;
         status     <= `SFS_STATUS_RESET;  // [RQ13]
         mem_req    <= '0;
      end else begin
         mem_req.cmd_valid <= 1'b0;
         mem_req.wr_valid  <= 1'b0;
         mem_req.rd_valid  <= 1'b0;
         if (mem_done && status.busy) begin
            status.busy <= 1'b0;  // [RQ18]
            status.write_latch_flag  <= 1'b0;  // [RQ15]
         end
         if (cs_rise) begin
            // write-type work only commits on a whole byte
            if (sel && bit_cnt[2:0] == 3'h0) begin
               if (state == S_DONE && opcode == `SFS_OP_PD) begin
                  power_down <= 1'b1;
               end else if (state == S_DONE) begin
                  mem_req.cmd_valid <= 1'b1;
                  mem_req.op <= (opcode == `SFS_OP_SE)   ? OP_ERASE4 :
                                (opcode == `SFS_OP_BE32) ? OP_ERASE32 :
                                (opcode == `SFS_OP_BE64) ? OP_ERASE64 :
                                OP_CHIP;
                  status.busy <= 1'b1;
               end else if (state == S_WDATA && got_byte) begin
                  mem_req.cmd_valid <= 1'b1;
                  status.busy <= 1'b1;
                  if (opcode == `SFS_OP_WRSR) begin
                     mem_req.op    <= OP_STATUS;
                     status.lock   <= new_sr[7];  // [RQ21]
                     status.side   <= new_sr[5];
                     status.size   <= new_sr[3:2];
                  end else begin
                     mem_req.op <= OP_PROGRAM;
                  end
               end
            end
            state    <= S_CMD;  // [RQ23]
            bit_cnt  <= 6'h00;
            shift    <= 8'h00;
            got_byte <= 1'b0;
            out_cnt  <= 3'h0;
            started  <= 1'b0;
         end else if (clk_rise && go) begin
            unique case (state)
               S_CMD: begin
                  shift   <= next_byte;
                  bit_cnt <= next_cnt;
                  if (bit_cnt == 6'h07) begin
                     opcode  <= opc;
                     bit_cnt <= 6'h00;
                     state   <= S_IGNORE;
                     case (opc)
                        `SFS_OP_RPD: begin
                           if (gate_ok)
                              power_down <= 1'b0;
                        end
                        `SFS_OP_WREN: begin
                           if (gate_ok && !puw_active)
                              status.write_latch_flag <= 1'b1;  // [RQ19]
                        end
                        `SFS_OP_WRDI: begin
                           if (gate_ok)
                              status.write_latch_flag <= 1'b0;  // [RQ19]
                        end
                        `SFS_OP_RDSR: begin
                           if (gate_ok)
                              state <= S_RDATA;
                        end
                        `SFS_OP_READ, `SFS_OP_FAST,
                        `SFS_OP_DOUT, `SFS_OP_DIO: begin
                           if (gate_ok)
                              state <= S_ADDR;
                        end
                        `SFS_OP_PROG, `SFS_OP_SE,
                        `SFS_OP_BE32, `SFS_OP_BE64: begin
                           if (wr_ok)
                              state <= S_ADDR;
                        end
                        `SFS_OP_CE, `SFS_OP_CE_ALT: begin
                           if (wr_ok && status.size == 2'b00)
                              state <= S_DONE;  // [RQ22]
                        end
                        `SFS_OP_WRSR: begin
                           // guard low with lock set keeps the status fixed
                           if (wr_ok && !(status.lock && !guard_s))
                              state <= S_WDATA;  // [RQ17] [RQ21]
                        end
                        `SFS_OP_PD: begin
                           if (gate_ok)
                              state <= S_DONE;
                        end
                        default: begin
                           state <= S_IGNORE;
                        end
                     endcase
                  end
               end
               S_ADDR: begin
                  addr_sh <= next_sh;
                  bit_cnt <= next_cnt;
                  if (next_cnt == ((opcode == `SFS_OP_DIO) ?
                                   `SFS_ADDR_BITS_DIO : `SFS_ADDR_BITS)) begin
                     bit_cnt      <= 6'h00;
                     mem_req.addr <= tgt;
                     if (opcode == `SFS_OP_READ || opcode == `SFS_OP_DIO) begin
                        state            <= S_RDATA;
                        mem_req.rd_valid <= 1'b1;
                     end else if (opcode == `SFS_OP_FAST ||
                                  opcode == `SFS_OP_DOUT) begin
                        state <= S_DUMMY;
                     end else if (prot_hit(status, tgt, span_of(opcode))) begin
                        state <= S_IGNORE;  // [RQ22]
                     end else begin
                        state <= (opcode == `SFS_OP_PROG) ? S_WDATA : S_DONE;
                     end
                  end
               end
               S_DUMMY: begin
                  bit_cnt <= next_cnt;
                  if (bit_cnt == 6'h07) begin
                     bit_cnt          <= 6'h00;
                     state            <= S_RDATA;
                     mem_req.rd_valid <= 1'b1;
                  end
               end
               S_WDATA: begin
                  shift   <= next_byte;
                  bit_cnt <= {3'h0, bit_cnt[2:0] + 3'h1};
                  if (bit_cnt[2:0] == 3'h7) begin
                     got_byte <= 1'b1;
                     if (opcode == `SFS_OP_WRSR) begin
                        new_sr <= next_byte;
                     end else begin
                        mem_req.wr_valid <= 1'b1;
                        mem_req.wdata    <= next_byte;
                        if (got_byte)
                           mem_req.addr[7:0] <= mem_req.addr[7:0] + 8'h01;
                     end
                  end
               end
               S_RDATA: begin
                  bit_cnt <= 6'h00;
               end
               S_DONE, S_IGNORE: begin
                  bit_cnt <= {3'h0, bit_cnt[2:0] + 3'h1};
               end
               default: begin
                  state <= S_IGNORE;
               end
            endcase
         end else if (clk_fall && go && state == S_RDATA) begin
            started <= 1'b1;
            if (out_cnt == 3'h0) begin
               drv1    <= rd_byte[7];  // [RQ3] [RQ6]
               drv0    <= rd_byte[6];
               obuf    <= dual_out ? {rd_byte[5:0], 2'b00}
                                   : {rd_byte[6:0], 1'b0};
               out_cnt <= dual_out ? 3'h3 : 3'h7;
               if (opcode != `SFS_OP_RDSR) begin
                  mem_req.addr     <= mem_req.addr + 18'h00001;
                  mem_req.rd_valid <= 1'b1;
               end
            end else begin
               drv1    <= obuf[7];
               drv0    <= obuf[6];
               obuf    <= dual_out ? {obuf[5:0], 2'b00} : {obuf[6:0], 1'b0};
               out_cnt <= out_cnt - 3'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------
   // floats a couple of cycles late after select rises; sync latency
   always_ff @(posedge clock) begin
      if (reset) begin
         dual_line_1_oe_n <= 1'b1;
         dual_line_0_oe_n <= 1'b1;
         dual_line_1_out  <= 1'b0;
         dual_line_0_out  <= 1'b0;
      end else begin
         dual_line_1_oe_n <= ~(go && state == S_RDATA && started); // [RQ24] [RQ1]
         dual_line_0_oe_n <= ~(go && state == S_RDATA && started
                               && dual_out);  // [RQ5] [RQ9]
         dual_line_1_out  <= drv1;
         dual_line_0_out  <= drv0;
      end
   end

endmodule
`default_nettype wire
